//--- hdl/flash_regs_pkg.sv
// constants for the status and configuration register block of a serial flash
package flash_regs_pkg;
   // opcodes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
   localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_WRITE_CONFIG = 8'h31;
   localparam logic [7:0] OP_CONFIG_READ = 8'h15;
   localparam logic [7:0] OP_BUSY_STREAM = 8'h25;
   localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
   localparam logic [7:0] OP_PROGRAM_SUSPEND = 8'hb0;
   localparam logic [7:0] OP_RESUME_A = 8'h7a;
   localparam logic [7:0] OP_RESUME_B = 8'h30;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   // status field positions
   localparam int BUSY_POS = 0;
   localparam int WEL_POS = 1;
   localparam int BP_LO_POS = 2;
   localparam int PROT_LO_POS = 7;
   localparam int PROT_HI_POS = 8;
   localparam int QE_POS = 9;
   localparam int PSUS_POS = 10;
   localparam int LOCK_LO_POS = 11;
   localparam int CMP_POS = 14;
   localparam int ESUS_POS = 15;
   // config field position
   localparam int DPAGE_POS = 7;
   // reset values
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   // status write cycle time
   localparam int WRITE_CYCLE_NS = 5000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WRITE_CYCLES = WRITE_CYCLE_NS / CLK_PERIOD_NS;
   // page sizes
   localparam int PAGE_SMALL = 256;
   localparam int PAGE_LARGE = 512;
endpackage

//--- hdl/wip_timer.sv
// self-timed write cycle counter driving the busy flag
`timescale 1ns/1ps
`default_nettype none
module wip_timer
   import flash_regs_pkg::*;
#(
   parameter int CYCLES = WRITE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // control
   input wire logic start_i,
   output logic busy_o
);
   // refuse a cycle count that the countdown cannot serve
   if (CYCLES < 1) begin : g_bad_cycles
      $error("cycles must be at least one");
   end
   // state of the timer
   typedef struct packed {
      logic busy;
      logic [31:0] cnt;
   } timer_t;
   timer_t s_q, s_d;
   // countdown, never restarts while busy
   always_comb begin
      s_d = s_q;
      if (!s_q.busy && start_i) begin
         s_d.busy = 1'b1;
         s_d.cnt = 32'(CYCLES - 1);
      end else if (s_q.busy) begin
         if (s_q.cnt == 32'h0) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.cnt = s_q.cnt - 32'h1;
         end
      end
   end
   // register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign busy_o = s_q.busy;
endmodule
`default_nettype wire

//--- hdl/flash_status_config_protect.sv
// status, configuration and protection logic of a serial flash
// Operation
// - protect 00: write allowed when latch set
// - protect 01, pin low, quad off: status writes refused, config writes still allowed
// - protect 01, pin high: writes allowed
// - protect 10: locked until power cycle
// - protect 11: locked until power cycle, as 10
// - quad enable repurposes protect/hold pins
// - three set-only security lock bits, cleared by power cycle
// - complement bit at status 14
// - suspend commands set suspend flags
// - resume or power cycle clears flags
// - config read answered even when busy
// - config byte out, upper lines ignored
// - dual-page bit at config bit 7
// - page size 256 or 512
// - buffer load wraps per dual-page bit
// - page erase covers dual page when dual-page bit set
// - busy stream shows live busy flag
// - busy flag never rises mid operation
// - chip select high ends stream, floats
// - busy flag is status bit 0
// - one-byte status write clears bits 14, 9 and 8
`timescale 1ns/1ps
`default_nettype none
module flash_status_config_protect
   import flash_regs_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES
) (
   // clock and power-on reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // serial link pins
   input wire logic CS_B_I,
   input wire logic SCLK_I,
   input wire logic SI_I,
   output logic SO_O,
   output logic SO_OE_B_O,
   // shared pins: protect/hold or io2/io3
   input wire logic WP_IO2_I,
   input wire logic HOLD_IO3_I,
   // buffer address from the load logic
   input wire logic [8:0] LOAD_ADDR_I,
   output logic [8:0] BUF_ADDR_O,
   output logic [9:0] PAGE_SIZE_O,
   output logic ERASE_DUAL_PAGE_O,
   // pin functions and lock state
   output logic QUAD_IO_ENABLE_O,
   output logic WRITE_PROTECT_B_O,
   output logic HOLD_B_O,
   output logic [2:0] SECURITY_LOCK_O,
   output logic [15:0] STATUS_O,
   output logic [7:0] CONFIG_O
);
   typedef enum logic [2:0] {ST_OPCODE, ST_DATA, ST_SHIFT_OUT, ST_STREAM, ST_IGNORE}
      phase_t;
   // whole state of the block
   typedef struct packed {
      logic [2:0] sync_cs;
      logic [2:0] sync_clk;
      logic [1:0] sync_si;
      logic [1:0] sync_wp;
      logic [1:0] sync_hold;
      phase_t phase;
      logic [7:0] opcode;
      logic [15:0] shreg;
      logic [4:0] bitcnt;
      logic [7:0] outbyte;
      logic so;
      logic so_en;
      logic [15:0] status;
      logic [7:0] config_r;
      logic start;
   } state_t;
   state_t s_q, s_d;
   logic busy;
   // synchronised pin levels (second stage)
   logic cs_b, sclk, si, wp_b, hold_b;
   logic sclk_rise, sclk_fall, cs_rise;
   assign cs_b = s_q.sync_cs[1];
   assign sclk = s_q.sync_clk[1];
   assign si = s_q.sync_si[1];
   assign wp_b = s_q.sync_wp[1];
   assign hold_b = s_q.sync_hold[1];
   assign sclk_rise = sclk && !s_q.sync_clk[2];
   assign sclk_fall = !sclk && s_q.sync_clk[2];
   assign cs_rise = cs_b && !s_q.sync_cs[2];

   // protection decision from protect bits and pin
   function automatic logic sr_write_ok(input logic [15:0] st, input logic wp, input logic qe);
      logic hi;
      logic lo;
      hi = st[PROT_HI_POS];
      lo = st[PROT_LO_POS];
      sr_write_ok = 1'b0;
      if (st[WEL_POS]) begin
         case ({hi, lo})
            2'b00: sr_write_ok = 1'b1;
            2'b01: sr_write_ok = qe | wp;
            2'b10: sr_write_ok = 1'b0;
            default: sr_write_ok = 1'b0;
         endcase
      end
   endfunction

   // self-timed write cycle
   wip_timer #(
      .CYCLES(WRITE_CYC)
   ) u_timer (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .start_i(s_q.start),
      .busy_o(busy)
   );

   // next state
   always_comb begin
      logic [15:0] nst;
      logic [7:0] op;
      nst = 16'h0;
      op = 8'h0;
      s_d = s_q;
      s_d.start = 1'b0;
      s_d.sync_cs = {s_q.sync_cs[1:0], CS_B_I};
      s_d.sync_clk = {s_q.sync_clk[1:0], SCLK_I};
      s_d.sync_si = {s_q.sync_si[0], SI_I};
      s_d.sync_wp = {s_q.sync_wp[0], WP_IO2_I};
      s_d.sync_hold = {s_q.sync_hold[0], HOLD_IO3_I};
      // busy mirrors the timer; latch clears when cycle ends
      s_d.status[BUSY_POS] = busy;
      if (s_q.status[BUSY_POS] && !busy) begin
         s_d.status[WEL_POS] = 1'b0;
      end
      if (cs_b) begin
         // frame end: execute writes on exact boundaries
         if (cs_rise && s_q.phase == ST_DATA && !busy) begin
            if (s_q.opcode == OP_WRITE_STATUS
                && sr_write_ok(s_q.status, wp_b, s_q.status[QE_POS])) begin
               nst = s_q.status;
               if (s_q.bitcnt == 5'd8) begin
                  nst[7:2] = s_q.shreg[7:2];
                  nst[CMP_POS] = 1'b0;
                  nst[QE_POS] = 1'b0;
                  nst[PROT_HI_POS] = 1'b0;
                  s_d.start = 1'b1;
               end else if (s_q.bitcnt == 5'd16) begin
                  nst[7:2] = s_q.shreg[15:10];
                  nst[CMP_POS] = s_q.shreg[CMP_POS - 8];
                  nst[QE_POS] = s_q.shreg[QE_POS - 8];
                  nst[PROT_HI_POS] = s_q.shreg[PROT_HI_POS - 8];
                  // lock bits only ever set
                  nst[13:11] = s_q.status[13:11] | s_q.shreg[13 - 8:11 - 8];
                  s_d.start = 1'b1;
               end
               if (s_d.start) begin
                  s_d.status = {s_q.status[ESUS_POS], nst[14:11], s_q.status[PSUS_POS],
                     nst[9:2], s_q.status[1:0]};
               end
            end else if (s_q.opcode == OP_WRITE_CONFIG && s_q.status[WEL_POS]
                && s_q.bitcnt == 5'd8) begin
               s_d.config_r[DPAGE_POS] = s_q.shreg[DPAGE_POS];
               s_d.start = 1'b1;
            end
         end
         s_d.phase = ST_OPCODE;
         s_d.bitcnt = 5'd0;
         s_d.so_en = 1'b0;
      end else begin
         case (s_q.phase)
            ST_OPCODE: begin
               if (sclk_rise) begin
                  op = {s_q.opcode[6:0], si};
                  s_d.opcode = op;
                  s_d.bitcnt = s_q.bitcnt + 5'd1;
                  if (s_q.bitcnt == 5'd7) begin
                     s_d.bitcnt = 5'd0;
                     s_d.phase = ST_IGNORE;
                     case (op)
                        OP_WRITE_ENABLE: s_d.status[WEL_POS] = !busy;
                        OP_WRITE_DISABLE: s_d.status[WEL_POS] = busy & s_q.status[WEL_POS];
                        OP_WRITE_STATUS, OP_WRITE_CONFIG: s_d.phase = ST_DATA;
                        OP_ERASE_SUSPEND: s_d.status[ESUS_POS] = 1'b1;
                        OP_PROGRAM_SUSPEND: s_d.status[PSUS_POS] = 1'b1;
                        OP_RESUME_A, OP_RESUME_B: begin
                           s_d.status[ESUS_POS] = 1'b0;
                           s_d.status[PSUS_POS] = 1'b0;
                        end
                        OP_CONFIG_READ: begin
                           s_d.outbyte = s_q.config_r;
                           s_d.phase = ST_SHIFT_OUT;
                        end
                        OP_READ_STATUS_LO: begin
                           s_d.outbyte = s_d.status[7:0];
                           s_d.phase = ST_SHIFT_OUT;
                        end
                        OP_READ_STATUS_HI: begin
                           s_d.outbyte = s_d.status[15:8];
                           s_d.phase = ST_SHIFT_OUT;
                        end
                        OP_BUSY_STREAM: s_d.phase = ST_STREAM;
                        default: s_d.phase = ST_IGNORE;
                     endcase
                  end
               end
            end
            ST_DATA: begin
               // count one past 16 so an overlong frame misses both boundaries
               if (sclk_rise && s_q.bitcnt != 5'd17) begin
                  s_d.shreg = {s_q.shreg[14:0], si};
                  s_d.bitcnt = s_q.bitcnt + 5'd1;
               end
            end
            ST_SHIFT_OUT: begin
               // msb first on falling edge, repeats the byte
               if (sclk_fall) begin
                  s_d.so = s_q.outbyte[7];
                  s_d.so_en = 1'b1;
                  s_d.outbyte = {s_q.outbyte[6:0], s_q.outbyte[7]};
               end
            end
            ST_STREAM: begin
               // live busy, no clock needed
               s_d.so = busy;
               s_d.so_en = 1'b1;
            end
            default: begin
               s_d.phase = ST_IGNORE;
            end
         endcase
      end
   end

   // register
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         s_q <= '0;
         s_q.sync_cs <= 3'h7;
         s_q.phase <= ST_OPCODE;
         s_q.status <= STATUS_RESET;
         s_q.config_r <= CONFIG_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign SO_O = s_q.so;
   assign SO_OE_B_O = !s_q.so_en;
   assign STATUS_O = s_q.status;
   assign CONFIG_O = s_q.config_r;
   assign QUAD_IO_ENABLE_O = s_q.status[QE_POS];
   assign WRITE_PROTECT_B_O = s_q.status[QE_POS] | wp_b;
   assign HOLD_B_O = s_q.status[QE_POS] | hold_b;
   assign SECURITY_LOCK_O = s_q.status[13:11];
   assign PAGE_SIZE_O = s_q.config_r[DPAGE_POS] ? 10'(PAGE_LARGE) : 10'(PAGE_SMALL);
   assign BUF_ADDR_O = s_q.config_r[DPAGE_POS] ? LOAD_ADDR_I : {1'b0, LOAD_ADDR_I[7:0]};
   assign ERASE_DUAL_PAGE_O = s_q.config_r[DPAGE_POS];

   // protect 10 or 11 freezes status bits 14:11 and 9:2
   property p_locked;
      @(posedge CLK_I) disable iff (!RST_B_I)
      // program suspend flag is read-only and may still move
      s_q.status[PROT_HI_POS] |=> $stable({s_q.status[14:11], s_q.status[9:2]});
   endproperty
   a_locked: assert property (p_locked) else $error("locked status changed");
   property p_hw_protect;
      @(posedge CLK_I) disable iff (!RST_B_I)
      (s_q.status[8:7] == 2'b01 && !wp_b && !s_q.status[QE_POS]) |-> !s_d.start
         || s_q.opcode == OP_WRITE_CONFIG;
   endproperty
   a_hw_protect: assert property (p_hw_protect) else $error("write under hw protect");
   property p_no_wel;
      @(posedge CLK_I) disable iff (!RST_B_I)
      !s_q.status[WEL_POS] |-> !s_d.start;
   endproperty
   a_no_wel: assert property (p_no_wel) else $error("write without latch");
   property p_stream;
      @(posedge CLK_I) disable iff (!RST_B_I)
      (s_q.phase == ST_STREAM && !cs_b) |=> (SO_O == $past(busy) && !SO_OE_B_O);
   endproperty
   a_stream: assert property (p_stream) else $error("stream not live busy");
   property p_cs_float;
      @(posedge CLK_I) disable iff (!RST_B_I)
      cs_b |=> SO_OE_B_O;
   endproperty
   a_cs_float: assert property (p_cs_float) else $error("output not floated");
   property p_wrap;
      @(posedge CLK_I) disable iff (!RST_B_I)
      !s_q.config_r[DPAGE_POS] |-> !BUF_ADDR_O[8];
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at 256");
   property p_lock_sticky;
      @(posedge CLK_I) disable iff (!RST_B_I)
      ($past(s_q.status[13:11]) & ~s_q.status[13:11]) == 3'h0;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
   property p_resume;
      @(posedge CLK_I) disable iff (!RST_B_I)
      (s_q.phase == ST_OPCODE && s_q.bitcnt == 5'd7 && sclk_rise && !cs_b
       && ({s_q.opcode[6:0], si} == OP_RESUME_A))
      |=> (s_q.status[ESUS_POS] == 1'b0 && s_q.status[PSUS_POS] == 1'b0);
   endproperty
   a_resume: assert property (p_resume) else $error("resume kept flags");
endmodule
`default_nettype wire

//--- test/spi_host_model.sv
// host side model that drives the serial link of the flash block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // serial link
   output logic cs_b_o,
   output logic sclk_o,
   output logic si_o,
   input wire logic so_i
);
   localparam int HALF = 80; // half period of the 160 ns link clock
   // idle link: deselected, clock parked low (mode 0)
   initial begin
      cs_b_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end
   // one frame: opcode, nw bits written, nr bits read, msb first
   task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nw,
      input int nr, input bit keep, output logic [7:0] rd);
      logic [23:0] sh;
      sh = {op, wd};
      rd = 8'h00;
      cs_b_o = 1'b0;
      for (int i = 0; i < 8 + nw + nr; i++) begin
         // bits after the opcode and data carry nothing, so keep them moving
         si_o = (i < 8 + nw) ? sh[23 - i] : ~si_o;
         #HALF;
         if (i >= 8 + nw) rd = {rd[6:0], so_i};
         sclk_o = 1'b1;
         #HALF;
         sclk_o = 1'b0;
      end
      if (!keep) done();
   endtask
   // end of frame: deselect, data line no longer meaningful
   task automatic done();
      #HALF;
      cs_b_o = 1'b1;
      si_o = ~si_o;
      #HALF;
   endtask
endmodule
`default_nettype wire

//--- test/flash_status_config_protect_tb.sv
// self-checking bench for the flash status and configuration block
`timescale 1ns/1ps
`default_nettype none
module flash_status_config_protect_tb;
   import flash_regs_pkg::*;
   localparam int WCYC = 400; // shortened write cycle
   logic clk = 1'b0, rst_b = 1'b0, wp = 1'b0, hold = 1'b1;
   logic cs_b, sclk, si, so, so_oe_b, erase_dp, quad, wp_b, hold_b;
   logic [8:0] load_addr = 9'h000;
   logic [8:0] buf_addr;
   logic [9:0] page_size;
   logic [2:0] lock;
   logic [15:0] status, st;
   logic [7:0] cfg, cf, rd;
   logic we;
   int n_errors = 0, checks = 0, ones, fell, bad;
   // clock
   initial begin
      forever #5 clk = ~clk;
   end
   spi_host_model spi_host_model_i (.cs_b_o(cs_b), .sclk_o(sclk), .si_o(si), .so_i(so));
   flash_status_config_protect #(.WRITE_CYC(WCYC)) flash_status_config_protect_i (
      .CLK_I(clk), .RST_B_I(rst_b), .CS_B_I(cs_b), .SCLK_I(sclk), .SI_I(si), .SO_O(so),
      .SO_OE_B_O(so_oe_b), .WP_IO2_I(wp), .HOLD_IO3_I(hold), .LOAD_ADDR_I(load_addr),
      .BUF_ADDR_O(buf_addr), .PAGE_SIZE_O(page_size), .ERASE_DUAL_PAGE_O(erase_dp),
      .QUAD_IO_ENABLE_O(quad), .WRITE_PROTECT_B_O(wp_b), .HOLD_B_O(hold_b),
      .SECURITY_LOCK_O(lock), .STATUS_O(status), .CONFIG_O(cfg));
   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one comparison
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // let synchronisers settle, then sample just after an edge
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask
   // opcode with optional data bits
   task automatic cmd(input logic [7:0] op, input logic [15:0] wd, input int nw);
      spi_host_model_i.frame(op, wd, nw, 0, 0, rd);
   endtask
   // watch for a self-timed cycle, then compare status except busy and latch
   task automatic idle(input bit exp);
      int i;
      bit seen;
      seen = 0;
      for (i = 0; i < 600; i++) begin
         @(posedge clk);
         #1;
         if (status[0] === 1'b1) seen = 1;
         else if (seen || i > 20) break;
      end
      if (i == 600) begin
         n_errors++;
         wrap_up();
      end
      chk("busy cycle", exp, seen);
      chk("status", st, status & 16'hfffc);
   endtask
   // status write through the model of the protection modes
   task automatic wr(input logic [7:0] b1, input logic [7:0] b2, input int nw, input bit en);
      bit ok;
      if (en) begin
         cmd(OP_WRITE_ENABLE, 16'h0000, 0);
         we = 1;
         settle();
         chk("latch", 1, status[WEL_POS]);
      end
      // only a frame ending after exactly 8 or 16 data bits executes
      ok = (nw == 8 || nw == 16) && we
         && (st[8:7] == 2'b00 || (st[8:7] == 2'b01 && (wp || st[QE_POS])));
      spi_host_model_i.frame(OP_WRITE_STATUS, {b1, b2}, (nw > 16) ? 16 : nw,
         (nw > 16) ? nw - 16 : 0, 0, rd);
      // suspend flags kept, lock bits only ever set
      if (ok && nw == 16) st = (st & 16'hbc00) | ({b2, b1} & 16'h7bfc);
      if (ok && nw == 8) st = (st & 16'hbc00) | {8'h00, b1 & 8'hfc};
      if (ok) we = 0;
      idle(ok);
   endtask
   // page size, wrap point and erase extent follow the dual-page bit
   task automatic page_chk();
      @(posedge clk);
      #1 load_addr = 9'($urandom);
      #2;
      chk("page size", cf[7] ? 16'd512 : 16'd256, page_size);
      chk("buffer addr", cf[7] ? load_addr : {8'h00, load_addr[7:0]}, buf_addr);
      chk("dual erase", cf[7], erase_dp);
      chk("config", cf, cfg);
   endtask
   // main sequence
   initial begin
      void'($urandom(42));
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      st = 16'h0000;
      cf = 8'h00;
      we = 0;
      settle();
      chk("status reset", STATUS_RESET, status);
      chk("drive off", 1, so_oe_b);
      page_chk();
      wr(8'h5c, 8'h00, 16, 0);
      wr({1'b1, 5'($urandom), 2'b00}, 8'h00, 16, 1);
      wr(8'h00, 8'h00, 16, 1);
      $display("test software and hardware protect done");
      @(posedge clk);
      #1 wp = 1'b1;
      wr(8'h80, 8'h48, 16, 1);
      chk("locks", 3'b001, lock);
      wr(8'h80, 8'h00, 8, 1);
      wr(8'h00, 8'h02, 16, 1);
      @(posedge clk);
      #1 wp = 1'b0;
      hold = 1'b0;
      settle();
      chk("quad pins", 3'b111, {quad, wp_b, hold_b});
      wr(8'h00, 8'h00, 16, 1);
      settle();
      chk("plain pins", 3'b000, {quad, wp_b, hold_b});
      hold = 1'b1;
      wr(8'h3c, 8'h00, 12, 1);
      wr(8'h3c, 8'h00, 17, 1);
      $display("test pin functions and locks done");
      for (int k = 0; k < 2; k++) begin
         cmd(OP_ERASE_SUSPEND, 16'h0000, 0);
         cmd(OP_PROGRAM_SUSPEND, 16'h0000, 0);
         st = st | 16'h8400;
         settle();
         chk("suspended", st, status & 16'hfffc);
         cmd(k ? OP_RESUME_B : OP_RESUME_A, 16'h0000, 0);
         st = st & 16'h7bff;
         settle();
         chk("resumed", st, status & 16'hfffc);
      end
      $display("test suspend done");
      cmd(OP_WRITE_ENABLE, 16'h0000, 0);
      cmd(OP_WRITE_CONFIG, 16'h8000, 8);
      cf = 8'h80;
      idle(1);
      page_chk();
      cmd(OP_WRITE_ENABLE, 16'h0000, 0);
      cmd(OP_WRITE_STATUS, 16'h0000, 16);
      spi_host_model_i.frame(OP_CONFIG_READ, 16'h0000, 0, 8, 0, rd);
      chk("busy at read", 1, status[BUSY_POS]);
      chk("config read", cf, rd);
      idle(1);
      $display("test config done");
      cmd(OP_WRITE_ENABLE, 16'h0000, 0);
      cmd(OP_WRITE_STATUS, 16'h0000, 16);
      spi_host_model_i.frame(OP_BUSY_STREAM, 16'h0000, 0, 0, 1, rd);
      ones = 0;
      fell = 0;
      bad = 0;
      for (int i = 0; i < 600; i++) begin
         @(posedge clk);
         #1;
         if (so === 1'b1) ones++;
         if (so === 1'b1 && fell > 0) bad = 1;
         if (so === 1'b0) fell = 1;
         if (fell > 0 && i > 50) break;
      end
      chk("stream high", 1, ones > 0);
      chk("stream fell", 1, fell);
      chk("stream rose", 0, bad);
      chk("stream drive", 0, so_oe_b);
      spi_host_model_i.done();
      settle();
      chk("stream float", 1, so_oe_b);
      chk("status", st, status & 16'hfffc);
      $display("test busy stream done");
      spi_host_model_i.frame(OP_READ_STATUS_HI, 16'h0000, 0, 8, 0, rd);
      chk("status hi read", {8'h00, st[15:8]}, {8'h00, rd});
      spi_host_model_i.frame(OP_READ_STATUS_LO, 16'h0000, 0, 8, 0, rd);
      chk("status lo read", {8'h00, st[7:0]}, {8'h00, rd});
      cmd(OP_WRITE_ENABLE, 16'h0000, 0);
      cmd(OP_WRITE_DISABLE, 16'h0000, 0);
      we = 0;
      settle();
      chk("latch off", 0, status[WEL_POS]);
      wr(8'h00, 8'h01, 16, 1);
      wr(8'h00, 8'h00, 16, 1);
      cmd(OP_ERASE_SUSPEND, 16'h0000, 0);
      @(posedge clk);
      #1 rst_b = 1'b0;
      @(posedge clk);
      #1 rst_b = 1'b1;
      st = 16'h0000;
      cf = 8'h00;
      settle();
      chk("power cycle", st, status);
      wr(8'h80, 8'h01, 16, 1);
      wr(8'h00, 8'h00, 16, 1);
      $display("test lock-down done");
      wrap_up();
   end
endmodule
`default_nettype wire
